// ==== src/slsiv_map.vh ====
// Register map, field positions, reset values and limits of the link status block
// Behaviour
// [R1] One alignment status bit per lane, eight bits
// [R2] Writing one to bit 7 clears pending interrupt
// [R3] Lane alignment status feeds summary flag 3
// [R4] Alignment loss also raises sync request outputs
// [R5] Checksum status bit one means checksum matched
// [R6] Octets per frame only 1, 2 or 4
// [R7] Test mode bit keeps receiver accepting alignment frames
// [R8] Software sets threshold gate when sync masks used
// [R9] Multiframe count times four, resets one, never zero
// [R10] Mask 7 and disparity threshold pull interrupt low
// [R11] Mask 6 and invalid symbol threshold pull low
// [R12] Mask 5 and stray control threshold pull low
// [R13] Mask 3 and alignment failure pull low
// [R14] Mask 2 and bad checksum pull low
// [R15] Mask 1 and frame lock failure pull low
// [R16] Mask 0 and symbol lock failure pull low
// [R17] Flags 7..5 set when any lane hits threshold
// [R18] Flags 3..0 set on any lane failure
// [R19] Bit 4 reserved, reads zero, no effect
// [R20] Per-lane error counters share one threshold
// [R21] Mask and flags share one address
// [R22] Interrupt is OR of masked flags
`ifndef SLSIV_MAP_VH
`define SLSIV_MAP_VH

`define SLSIV_ADDR_W          11
`define SLSIV_OFS_CKSUM_STAT  11'h472
`define SLSIV_OFS_ALIGN_STAT  11'h473
`define SLSIV_OFS_FRAME_OCT   11'h476
`define SLSIV_OFS_CTRL_TWO    11'h477
`define SLSIV_OFS_MF_COUNT    11'h478
`define SLSIV_OFS_IRQ_VEC     11'h47a
`define SLSIV_OFS_SYNC_MASK   11'h47b
`define SLSIV_OFS_ERR_LIMIT   11'h47c

`define SLSIV_RST_FRAME_OCT   8'h01
`define SLSIV_RST_CTRL_TWO    8'h00
`define SLSIV_RST_MF_COUNT    8'h01
`define SLSIV_RST_IRQ_EN      8'h00
`define SLSIV_RST_SYNC_MASK   8'h00
`define SLSIV_RST_ERR_LIMIT   8'hff

`define SLSIV_BIT_CLEAR_IRQ   7
`define SLSIV_BIT_TEST_MODE   7
`define SLSIV_BIT_THR_GATE    3
`define SLSIV_BIT_DISP        7
`define SLSIV_BIT_INVS        6
`define SLSIV_BIT_STRAY       5
`define SLSIV_BIT_RSVD        4
`define SLSIV_BIT_ALIGN       3
`define SLSIV_BIT_CKSUM       2
`define SLSIV_BIT_FRAME       1
`define SLSIV_BIT_SYMB        0
`define SLSIV_IRQ_VALID_MASK  8'hef
`define SLSIV_CTRL_TWO_MASK   8'h88
`define SLSIV_SYNC_MASK_BITS  8'he0
`define SLSIV_CNT_FLAG_BITS   8'he0

`define SLSIV_OCT_ONE         8'h01
`define SLSIV_OCT_TWO         8'h02
`define SLSIV_OCT_FOUR        8'h04

`endif

// ==== src/slsiv_err_counter.v ====
// Saturating per-lane error counter with threshold compare
module slsiv_err_counter #(
	parameter CNT_W = 8
) (
	// Clock and reset
	input  wire             clk,
	input  wire             reset_n,
	// Error event and limit
	input  wire             err_pulse,
	input  wire             cnt_clear,
	input  wire [CNT_W-1:0] limit,
	// Result
	output wire             at_limit
);
	reg [CNT_W-1:0] count_q;

	// Count errors, hold at all ones
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= {CNT_W{1'b0}};
		end else if (cnt_clear) begin
			count_q <= {{(CNT_W-1){1'b0}}, err_pulse}; // Event in the clear cycle still counts
		end else if (err_pulse && (count_q != {CNT_W{1'b1}})) begin
			count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Threshold shared by all lanes
	assign at_limit = (count_q >= limit); // [R20]
endmodule

// ==== src/slsiv_sync2.v ====
// Two-stage synchroniser for a vector of pin-level inputs
module slsiv_sync2 #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         clk,
	input  wire         reset_n,
	// Data
	input  wire [W-1:0] d_async,
	output wire [W-1:0] d_sync
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// Meta stage read only by the second stage
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d_async;
			sync_q <= meta_q;
		end
	end

	assign d_sync = sync_q;
endmodule

// ==== src/slsiv_top.v ====
// Link status, configuration and interrupt vector block
`include "slsiv_map.vh"

module slsiv_top #(
	parameter LANES = 8,
	parameter CNT_W = 8
) (
	// Clock and reset
	input  wire                     clk,
	input  wire                     reset_n,
	// Register port
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	input  wire [`SLSIV_ADDR_W-1:0] reg_addr,
	input  wire [7:0]               reg_wdata,
	output reg  [7:0]               reg_rdata,
	// Lane status from the lane decoders
	input  wire [LANES-1:0]         lane_align_ok,
	input  wire [LANES-1:0]         lane_cksum_ok,
	input  wire [LANES-1:0]         lane_frame_lock,
	input  wire [LANES-1:0]         lane_symbol_lock,
	// Per-lane error events, one cycle each
	input  wire [LANES-1:0]         disparity_err,
	input  wire [LANES-1:0]         invalid_symbol_err,
	input  wire [LANES-1:0]         stray_control_err,
	// Configuration outputs
	output wire [7:0]               octets_per_frame,
	output wire                     align_seq_test_mode,
	output wire [7:0]               multiframe_count_div4,
	output wire [9:0]               align_seq_multiframes,
	// Link and interrupt outputs
	output reg                      sync_request_out_a,
	output reg                      sync_request_out_b,
	output reg                      irq_n
);
	// Registers
	reg  [7:0]       frame_oct_q;
	reg  [7:0]       ctrl_two_q;
	reg  [7:0]       mf_count_q;
	reg  [7:0]       irq_en_q;
	reg  [7:0]       sync_mask_q;
	reg  [7:0]       err_limit_q;
	reg  [7:0]       flags_q;
	reg  [7:0]       flags_d;
	reg  [7:0]       lane_align_q;
	reg  [7:0]       cksum_q;
	wire [LANES-1:0] align_s;
	wire [LANES-1:0] cksum_s;
	wire [LANES-1:0] frame_s;
	wire [LANES-1:0] symb_s;
	wire [LANES-1:0] disp_hit;
	wire [LANES-1:0] invs_hit;
	wire [LANES-1:0] stray_hit;
	wire [7:0]       lane_align_status_bits;
	wire [7:0]       raw_fail;
	wire [7:0]       masked;
	reg  [1:0]       prime_q;
	wire [7:0]       fresh_fail;
	wire             wr_align;
	wire             wr_frame_oct;
	wire             wr_ctrl_two;
	wire             wr_mf_count;
	wire             wr_irq_vec;
	wire             wr_sync_mask;
	wire             wr_err_limit;
	wire             oct_legal;
	wire             lanes_valid;
	wire             clr_irq;
	wire             gate_en;
	wire             sync_req_d;
	wire             test_mode_bit;

	// Pin-level lane status crosses into the clock domain
	slsiv_sync2 #(.W(LANES)) u_sync_align (
		.clk     (clk),
		.reset_n (reset_n),
		.d_async (lane_align_ok),
		.d_sync  (align_s)
	);
	slsiv_sync2 #(.W(LANES)) u_sync_cksum (
		.clk     (clk),
		.reset_n (reset_n),
		.d_async (lane_cksum_ok),
		.d_sync  (cksum_s)
	);
	slsiv_sync2 #(.W(LANES)) u_sync_frame (
		.clk     (clk),
		.reset_n (reset_n),
		.d_async (lane_frame_lock),
		.d_sync  (frame_s)
	);
	slsiv_sync2 #(.W(LANES)) u_sync_symb (
		.clk     (clk),
		.reset_n (reset_n),
		.d_async (lane_symbol_lock),
		.d_sync  (symb_s)
	);

	// Three counters per lane against the shared limit
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			slsiv_err_counter #(.CNT_W(CNT_W)) u_disp (
				.clk       (clk),
				.reset_n   (reset_n),
				.err_pulse (disparity_err[g]),
				.cnt_clear (clr_irq),
				.limit     (err_limit_q[CNT_W-1:0]),
				.at_limit  (disp_hit[g])
			); // [R20]
			slsiv_err_counter #(.CNT_W(CNT_W)) u_invs (
				.clk       (clk),
				.reset_n   (reset_n),
				.err_pulse (invalid_symbol_err[g]),
				.cnt_clear (clr_irq),
				.limit     (err_limit_q[CNT_W-1:0]),
				.at_limit  (invs_hit[g])
			); // [R20]
			slsiv_err_counter #(.CNT_W(CNT_W)) u_stray (
				.clk       (clk),
				.reset_n   (reset_n),
				.err_pulse (stray_control_err[g]),
				.cnt_clear (clr_irq),
				.limit     (err_limit_q[CNT_W-1:0]),
				.at_limit  (stray_hit[g])
			); // [R20]
		end
	endgenerate

	// Write strobes, one per register
	assign wr_align     = reg_wr && (reg_addr == `SLSIV_OFS_ALIGN_STAT);
	assign wr_frame_oct = reg_wr && (reg_addr == `SLSIV_OFS_FRAME_OCT);
	assign wr_ctrl_two  = reg_wr && (reg_addr == `SLSIV_OFS_CTRL_TWO);
	assign wr_mf_count  = reg_wr && (reg_addr == `SLSIV_OFS_MF_COUNT);
	assign wr_irq_vec   = reg_wr && (reg_addr == `SLSIV_OFS_IRQ_VEC);
	assign wr_sync_mask = reg_wr && (reg_addr == `SLSIV_OFS_SYNC_MASK);
	assign wr_err_limit = reg_wr && (reg_addr == `SLSIV_OFS_ERR_LIMIT);
	assign clr_irq      = wr_align && reg_wdata[`SLSIV_BIT_CLEAR_IRQ]; // [R2]

	// Only legal frame sizes are accepted
	assign oct_legal = (reg_wdata == `SLSIV_OCT_ONE) || (reg_wdata == `SLSIV_OCT_TWO) ||
		(reg_wdata == `SLSIV_OCT_FOUR); // [R6]

	// Octets per frame
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_oct_q <= `SLSIV_RST_FRAME_OCT;
		end else if (wr_frame_oct && oct_legal) begin
			frame_oct_q <= reg_wdata; // [R6]
		end
	end

	// Control two keeps test mode and threshold gate only
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_two_q <= `SLSIV_RST_CTRL_TWO;
		end else if (wr_ctrl_two) begin
			ctrl_two_q <= reg_wdata & `SLSIV_CTRL_TWO_MASK; // [R7]
		end
	end

	// Multiframe count, zero would give an empty alignment sequence
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mf_count_q <= `SLSIV_RST_MF_COUNT; // [R9]
		end else if (wr_mf_count && (reg_wdata != 8'h00)) begin
			mf_count_q <= reg_wdata; // [R9]
		end
	end

	// Interrupt mask, shares its address with the flags
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_q <= `SLSIV_RST_IRQ_EN;
		end else if (wr_irq_vec) begin
			irq_en_q <= reg_wdata & `SLSIV_IRQ_VALID_MASK; // [R21] [R19]
		end
	end

	// Sync request mask for counted errors
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_mask_q <= `SLSIV_RST_SYNC_MASK;
		end else if (wr_sync_mask) begin
			sync_mask_q <= reg_wdata & `SLSIV_SYNC_MASK_BITS;
		end
	end

	// Error limit shared by all lanes
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			err_limit_q <= `SLSIV_RST_ERR_LIMIT;
		end else if (wr_err_limit) begin
			err_limit_q <= reg_wdata; // [R20]
		end
	end

	// Live alignment status, unused lanes read zero
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lane_align_q <= 8'h00;
		end else begin
			lane_align_q <= {{(8-LANES){1'b0}}, align_s}; // [R1]
		end
	end
	assign lane_align_status_bits = lane_align_q;

	// Live checksum status, one means the last checksum matched
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cksum_q <= 8'h00;
		end else begin
			cksum_q <= {{(8-LANES){1'b0}}, cksum_s}; // [R5]
		end
	end

	// Lane status trusted once both sync stages hold pin values
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prime_q <= 2'b00;
		end else begin
			prime_q <= {prime_q[0], 1'b1};
		end
	end
	assign lanes_valid = prime_q[1]; // Avoids false failures right after reset

	// Raw failure conditions per summary bit
	assign raw_fail[`SLSIV_BIT_DISP]  = |disp_hit; // [R17]
	assign raw_fail[`SLSIV_BIT_INVS]  = |invs_hit; // [R17]
	assign raw_fail[`SLSIV_BIT_STRAY] = |stray_hit; // [R17]
	assign raw_fail[`SLSIV_BIT_RSVD]  = 1'b0; // [R19]
	assign raw_fail[`SLSIV_BIT_ALIGN] = lanes_valid & (|(~align_s)); // [R3] [R18]
	assign raw_fail[`SLSIV_BIT_CKSUM] = lanes_valid & (|(~cksum_s)); // [R18]
	assign raw_fail[`SLSIV_BIT_FRAME] = lanes_valid & (|(~frame_s)); // [R18]
	assign raw_fail[`SLSIV_BIT_SYMB]  = lanes_valid & (|(~symb_s)); // [R18]

	// Counters restart on a clear, so the clear consumes their flags
	assign fresh_fail = clr_irq ? (raw_fail & ~`SLSIV_CNT_FLAG_BITS) : raw_fail;

	// Sticky flags: a new lane failure (bits 3..0) wins over a clear in the same cycle
	always @* begin
		flags_d = flags_q;
		if (clr_irq) begin
			flags_d = 8'h00; // [R2]
		end
		flags_d = (flags_d | fresh_fail) & `SLSIV_IRQ_VALID_MASK; // [R17] [R18]
	end

	// Flag register
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_q <= 8'h00;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Masked flags drive the interrupt
	assign masked = flags_q & irq_en_q & `SLSIV_IRQ_VALID_MASK; // [R10] [R11] [R12] [R13] [R14] [R15] [R16]

	// Sync request on symbol lock or alignment loss, counted errors when gated
	assign gate_en    = ctrl_two_q[`SLSIV_BIT_THR_GATE]; // [R8]
	assign sync_req_d = raw_fail[`SLSIV_BIT_ALIGN] | raw_fail[`SLSIV_BIT_SYMB] | // [R4]
		(gate_en & |(sync_mask_q & raw_fail & `SLSIV_SYNC_MASK_BITS));

	// Interrupt output
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~(|masked); // [R22]
		end
	end

	// Both sync outputs carry the same request
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_request_out_a <= 1'b0;
			sync_request_out_b <= 1'b0;
		end else begin
			sync_request_out_a <= sync_req_d; // [R4]
			sync_request_out_b <= sync_req_d; // [R4]
		end
	end

	// Register read mux
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`SLSIV_OFS_CKSUM_STAT: reg_rdata <= cksum_q; // [R5]
				`SLSIV_OFS_ALIGN_STAT: reg_rdata <= lane_align_status_bits; // [R1]
				`SLSIV_OFS_FRAME_OCT:  reg_rdata <= frame_oct_q;
				`SLSIV_OFS_CTRL_TWO:   reg_rdata <= ctrl_two_q;
				`SLSIV_OFS_MF_COUNT:   reg_rdata <= mf_count_q;
				`SLSIV_OFS_IRQ_VEC:    reg_rdata <= flags_q; // [R21]
				`SLSIV_OFS_SYNC_MASK:  reg_rdata <= sync_mask_q;
				`SLSIV_OFS_ERR_LIMIT:  reg_rdata <= err_limit_q;
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end

	// Configuration outputs
	assign test_mode_bit         = ctrl_two_q[`SLSIV_BIT_TEST_MODE];
	assign align_seq_test_mode   = test_mode_bit; // [R7]
	assign octets_per_frame      = frame_oct_q;
	assign multiframe_count_div4 = mf_count_q;
	assign align_seq_multiframes = {mf_count_q, 2'b00}; // [R9]
endmodule

// ==== testbench/slsiv_tx_model.sv ====
// Far-side transmitter model: lane status levels and error bursts
module slsiv_tx_model (
	// Clock
	input  wire        clk,
	// Bench commands
	input  wire  [3:0] fail_kind,
	input  wire  [2:0] err_req,
	// Lane status, lane 0 fails on demand
	output wire  [7:0] lane_symbol_lock,
	output wire  [7:0] lane_frame_lock,
	output wire  [7:0] lane_cksum_ok,
	output wire  [7:0] lane_align_ok,
	// Error pulses on lane 3
	output logic [7:0] disparity_err = 8'h00,
	output logic [7:0] invalid_symbol_err = 8'h00,
	output logic [7:0] stray_control_err = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// Status levels
	assign lane_symbol_lock = fail_kind[0] ? 8'hfe : 8'hff;
	assign lane_frame_lock  = fail_kind[1] ? 8'hfe : 8'hff;
	assign lane_cksum_ok    = fail_kind[2] ? 8'hfe : 8'hff;
	assign lane_align_ok    = fail_kind[3] ? 8'hfe : 8'hff;
	// One error per cycle while requested
	always @(posedge clk) begin
		disparity_err      <= {4'h0, err_req[0], 3'h0};
		invalid_symbol_err <= {4'h0, err_req[1], 3'h0};
		stray_control_err  <= {4'h0, err_req[2], 3'h0};
	end
endmodule

// ==== testbench/slsiv_top_asserts.sv ====
// Port assertions for the link status block
module slsiv_top_asserts #(
	parameter LANES = 8,
	parameter CNT_W = 8
) (
	// Clock, reset, register port
	input wire             clk,
	input wire             reset_n,
	input wire             reg_wr,
	input wire             reg_rd,
	input wire [10:0]      reg_addr,
	input wire [7:0]       reg_wdata,
	input wire [7:0]       reg_rdata,
	// Lane status
	input wire [LANES-1:0] lane_align_ok,
	input wire [LANES-1:0] lane_symbol_lock,
	// Outputs
	input wire [7:0]       octets_per_frame,
	input wire             align_seq_test_mode,
	input wire [7:0]       multiframe_count_div4,
	input wire [9:0]       align_seq_multiframes,
	input wire             sync_request_out_a,
	input wire             sync_request_out_b,
	input wire             irq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] en_q;
	wire        tm_w = reg_wdata[7];
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Shadow of the written interrupt mask
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			en_q <= 8'h00;
		else if (reg_wr && reg_addr == 11'h47a)
			en_q <= reg_wdata & 8'hef;
	end
	rsvd_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 11'h47a |-> !reg_rdata[4])
		else $error("reserved flag set");
	mf_times4_a: assert property (align_seq_multiframes == {multiframe_count_div4, 2'b00})
		else $error("multiframe length wrong");
	mf_nonzero_a: assert property (multiframe_count_div4 != 8'h00)
		else $error("multiframe count zero");
	oct_legal_a: assert property (octets_per_frame == 8'h01 || octets_per_frame == 8'h02 || octets_per_frame == 8'h04)
		else $error("octets per frame illegal");
	sync_pair_a: assert property (sync_request_out_a == sync_request_out_b)
		else $error("sync outputs differ");
	test_mode_a: assert property (reg_wr && reg_addr == 11'h477 |=> align_seq_test_mode == $past(tm_w))
		else $error("test mode not stored");
	irq_quiet_a: assert property ((en_q == 8'h00) [*2] |-> irq_n)
		else $error("irq low with no mask");
	align_irq_a: assert property ((en_q[3] && !(&lane_align_ok)) [*6] |=> !irq_n)
		else $error("alignment irq missing");
	symb_irq_a: assert property ((en_q[0] && !(&lane_symbol_lock)) [*6] |=> !irq_n)
		else $error("symbol lock irq missing");
	align_sync_a: assert property (!(&lane_align_ok) [*5] |=> sync_request_out_a)
		else $error("sync request missing");
endmodule

bind slsiv_top slsiv_top_asserts #(.LANES(LANES), .CNT_W(CNT_W)) u_chk (.clk, .reset_n, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .lane_align_ok, .lane_symbol_lock, .octets_per_frame,
	.align_seq_test_mode, .multiframe_count_div4, .align_seq_multiframes, .sync_request_out_a,
	.sync_request_out_b, .irq_n);

// ==== testbench/tb_top.sv ====
// Self-checking bench for the link status block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset_n, reg_wr, reg_rd, tm, sra, srb, irq_n;
	logic [10:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, opf, mfc, rv;
	logic [9:0]  asmf;
	logic [7:0]  lane_align_ok, lane_cksum_ok, lane_frame_lock, lane_symbol_lock;
	logic [7:0]  disparity_err, invalid_symbol_err, stray_control_err;
	logic [3:0]  fail_kind;
	logic [2:0]  err_req;
	int          err_total, total_checks;
	// Rows: address, write data, expected readback and port value
	logic [26:0] rows [8] = '{{11'h476, 8'h02, 8'h02}, {11'h476, 8'h04, 8'h04}, {11'h476, 8'h03, 8'h04},
		{11'h476, 8'h01, 8'h01}, {11'h478, 8'h05, 8'h05}, {11'h478, 8'h00, 8'h05},
		{11'h477, 8'h80, 8'h80}, {11'h477, 8'h00, 8'h00}};
	slsiv_tx_model tx (.clk, .fail_kind, .err_req, .lane_symbol_lock, .lane_frame_lock, .lane_cksum_ok,
		.lane_align_ok, .disparity_err, .invalid_symbol_err, .stray_control_err);
	slsiv_top dut (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .lane_align_ok,
		.lane_cksum_ok, .lane_frame_lock, .lane_symbol_lock, .disparity_err, .invalid_symbol_err,
		.stray_control_err, .octets_per_frame(opf), .align_seq_test_mode(tm), .multiframe_count_div4(mfc),
		.align_seq_multiframes(asmf), .sync_request_out_a(sra), .sync_request_out_b(srb), .irq_n);
	// Clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
		cyc(1);
	endtask
	task automatic rd(input logic [10:0] a);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		cyc(1);
		rv = reg_rdata;
	endtask
	function automatic logic [7:0] obs(input logic [10:0] a);
		if (a == 11'h476) return opf;
		if (a == 11'h478) return mfc;
		return {tm, 7'h00};
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(3000 * 25);
		err_total++;
		stop_test();
	end
	// Main sequence
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, fail_kind, err_req} = '0;
		cyc(10);
		reset_n = 1;
		rd(11'h476); check("frame_oct", rv, 8'h01);
		rd(11'h478); check("mf_count", rv, 8'h01);
		rd(11'h477); check("ctrl_two", rv, 8'h00);
		rd(11'h479); check("unmapped", rv, 8'h00);
		check("irq_idle", irq_n, 1'b1);
		$display("done: reset values");
		foreach (rows[i]) begin
			wr(rows[i][26:16], rows[i][15:8]);
			rd(rows[i][26:16]);
			check("readback", rv, rows[i][7:0]);
			check("port", obs(rows[i][26:16]), rows[i][7:0]);
		end
		$display("done: config rows");
		wr(11'h473, 8'h80);
		wr(11'h47a, 8'h10);
		cyc(3);
		rd(11'h47a); check("flags_idle", rv, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(11'h47a, 8'h00);
			fail_kind = 4'(1 << k);
			cyc(6);
			check("irq_masked", irq_n, 1'b1);
			if (k == 0 || k == 3) check("sync_req", sra, 1'b1);
			else check("sync_quiet", sra, 1'b0);
			if (k >= 2) rd((k == 3) ? 11'h473 : 11'h472);
			if (k >= 2) check("lane_live", rv, 8'hfe);
			wr(11'h47a, 8'(1 << k));
			cyc(8);
			check("irq_low", irq_n, 1'b0);
			fail_kind = 0;
			cyc(6);
			rd(11'h47a); check("sticky", rv, 8'(1 << k));
			wr(11'h473, 8'h80);
			cyc(3);
			check("irq_clear", irq_n, 1'b1);
			rd(11'h47a); check("flags_clear", rv, 8'h00);
		end
		$display("done: lane failures");
		wr(11'h47c, 8'h03);
		for (int e = 0; e < 3; e++) begin
			wr(11'h47a, 8'(8'h80 >> e));
			err_req = 3'(1 << e);
			cyc(2);
			err_req = 0;
			cyc(4);
			check("below_limit", irq_n, 1'b1);
			err_req = 3'(1 << e);
			cyc(1);
			err_req = 0;
			cyc(4);
			check("at_limit", irq_n, 1'b0);
			rd(11'h47a); check("err_flag", rv, 8'(8'h80 >> e));
			wr(11'h473, 8'h80);
			cyc(3);
			rd(11'h47a); check("err_clear", rv, 8'h00);
		end
		$display("done: error counts");
		wr(11'h477, 8'h08);
		wr(11'h47b, 8'h80);
		err_req = 3'h1;
		cyc(3);
		err_req = 0;
		cyc(4);
		check("sync_errors", sra, 1'b1);
		$display("done: sync on errors");
		wr(11'h476, 8'h02);
		reset_n = 0;
		cyc(2);
		check("rst_irq", irq_n, 1'b1);
		check("rst_oct", opf, 8'h01);
		reset_n = 1;
		rd(11'h476); check("rst_oct_rd", rv, 8'h01);
		cyc(3);
		rd(11'h47a); check("rst_flags", rv, 8'h00);
		$display("done: second reset");
		stop_test();
	end
endmodule
